// >>> hw/kbc_pkg.sv
package kbc_pkg;

  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned PWRUP_MS   = 150;
  localparam int unsigned TEST_MS    = 350;
  localparam int unsigned ACCEPT_US  = 500;
  localparam int unsigned PWRUP_CYC  = PWRUP_MS * (CLK_HZ / 1000);
  localparam int unsigned TEST_CYC   = TEST_MS * (CLK_HZ / 1000);
  localparam int unsigned ACCEPT_CYC = ACCEPT_US * (CLK_HZ / 1_000_000);

  // Host command bytes
  localparam logic [7:0] C_LED    = 8'hed;
  localparam logic [7:0] C_ECHO   = 8'hee;
  localparam logic [7:0] C_BAD0   = 8'hef;
  localparam logic [7:0] C_SET    = 8'hf0;
  localparam logic [7:0] C_BAD1   = 8'hf1;
  localparam logic [7:0] C_ID     = 8'hf2;
  localparam logic [7:0] C_RATE   = 8'hf3;
  localparam logic [7:0] C_ENA    = 8'hf4;
  localparam logic [7:0] C_DDIS   = 8'hf5;
  localparam logic [7:0] C_DEF    = 8'hf6;
  localparam logic [7:0] C_ALL_T  = 8'hf7;
  localparam logic [7:0] C_ALL_MK = 8'hfa;
  localparam logic [7:0] C_KEY_T  = 8'hfb;
  localparam logic [7:0] C_KEY_MB = 8'hfc;
  localparam logic [7:0] C_KEY_MK = 8'hfd;
  localparam logic [7:0] C_RESEND = 8'hfe;
  localparam logic [7:0] C_RESET  = 8'hff;

  // Keyboard reply bytes
  localparam logic [7:0] R_PASS   = 8'haa;
  localparam logic [7:0] R_FAIL   = 8'hfc;
  localparam logic [7:0] R_ECHO   = 8'hee;
  localparam logic [7:0] R_ACK    = 8'hfa;
  localparam logic [7:0] R_RESEND = 8'hfe;

  localparam logic [7:0] LED_RSV   = 8'hf8;
  localparam logic [7:0] SET_QUERY = 8'h00;
  localparam logic [7:0] SET_MAX   = 8'h03;
  localparam logic [7:0] RATE_RST  = 8'h2b;
  localparam logic [7:0] LAST_RST  = 8'h00;
  localparam logic [1:0] SET_RST   = 2'h2;
  localparam logic [2:0] LED_RST   = 3'h0;
  localparam logic [2:0] LED_ALL   = 3'h7;

  typedef enum logic [4:0] {
    ST_PWRUP = 5'h01,
    ST_TEST  = 5'h02,
    ST_IDLE  = 5'h04,
    ST_OPT   = 5'h08,
    ST_RSTW  = 5'h10
  } kbc_state_e;

  typedef enum logic [3:0] {
    OPT_LED  = 4'h1,
    OPT_RATE = 4'h2,
    OPT_SET  = 4'h4,
    OPT_KEY  = 4'h8
  } kbc_opt_e;

  typedef struct packed {
    logic       perr;
    logic [7:0] data;
  } kbc_rx_s;

endpackage : kbc_pkg

// >>> hw/kbc_cmd.sv
// Notes on behaviour
// - Self-test lasts 300 to 500 ms
// - Link ignored and lamps lit during self-test
// - Pass sends AA and scans; fail FC, disabled
// - Result code timed from power-on or reset
// - Command byte codes ED through FF decoded
// - Commands accepted outside power-up and self-test, answered quickly
// - F5/F6 acknowledge, flush, restore defaults
// - Echo answers EE, scanning state kept
// - Enable acknowledges, flushes, starts scanning
// - EF and F1 answer resend, nothing else
// - Identify: acknowledge, halt, two ID bytes
// - Resend repeats last byte, skipping resends
// - Reset acknowledged, waits for idle lines
// - Disabled until reset accepted or overridden
// - Reset reruns self-test, then set two on a pass
// - Scan-set select takes option 01 to 03
// - Option 00 reports the current set
// - Scan-set select restores prior scanning state
// - All-key type commands set every key
// - Per-key type commands name set-3 keys
// - Indicator command halts, awaits option byte
// - Option bits light or clear each lamp
// - Valid bytes other than echo and resend acknowledged with FA
// - Invalid or bad-parity bytes answer resend
`timescale 1ns/1ns
`default_nettype none
module kbc_cmd #(
  parameter int unsigned PWRUP_CYC  = kbc_pkg::PWRUP_CYC,
  parameter int unsigned TEST_CYC   = kbc_pkg::TEST_CYC,
  parameter int unsigned ACCEPT_CYC = kbc_pkg::ACCEPT_CYC,
  parameter logic [7:0]  ID_LO      = 8'h5a, // Arbitrary identity value
  parameter logic [7:0]  ID_HI      = 8'hc3  // Arbitrary identity value
) (
  input  wire logic            sys_clk,       // Core clock
  input  wire logic            srst,          // Sync reset, high
  input  wire logic            link_clk,      // Link-side clock
  input  wire logic            rx_valid,      // Byte received, link pulse
  input  wire kbc_pkg::kbc_rx_s rx_evt,       // Received byte and parity
  input  wire logic            tx_ready,      // Transmitter takes byte
  output logic [7:0]           tx_byte,       // Byte to transmit
  output logic                 tx_valid,      // Byte waiting, link domain
  input  wire logic            line_clk_in,   // Clock line level
  input  wire logic            line_data_in,  // Data line level
  input  wire logic            self_test_ok,  // Memory checks passed
  output logic                 scan_en,       // Key scanning enabled
  output logic [1:0]           scan_set,      // Active scan code set
  output logic [2:0]           led,           // Caps, num, scroll lamps
  output logic [7:0]           rate_cfg,      // Repeat rate and delay
  output logic                 flush_buf,     // Empty output buffer
  output logic                 clr_typematic, // Forget repeating key
  output logic                 defaults_load, // Restore key types
  output logic                 all_type_we,   // Set type of all keys
  output logic                 key_type_we,   // Set type of key_code
  output logic [1:0]           key_type,      // Type for either write
  output logic [7:0]           key_code,      // Set-3 key named
  output logic                 self_test_busy // Power-up or self-test
);

  function automatic logic is_all(input logic [7:0] d);
    return d >= kbc_pkg::C_ALL_T && d <= kbc_pkg::C_ALL_MK;
  endfunction : is_all

  function automatic logic is_key(input logic [7:0] d);
    return d >= kbc_pkg::C_KEY_T && d <= kbc_pkg::C_KEY_MK;
  endfunction : is_key

  kbc_pkg::kbc_state_e st;
  kbc_pkg::kbc_opt_e   opt;
  kbc_pkg::kbc_rx_s    rx_hold;
  logic [25:0] tmr;
  logic [15:0] acc;
  logic [1:0]  ktype;
  logic        rx_tog, rx_s1, rx_s2, rx_s3, rx_seen, rx_ev;
  logic        lrst_s1, link_rst;
  logic        tx_req_tog, rq_s1, rq_s2, rq_s3, rq_seen;
  logic        ack_tog, ack_s1, ack_s2, ack_s3, ack_q;
  logic [1:0]  lin_s1, lin_s2, lin_s3, lin_q;
  logic [7:0]  txq [4];
  logic [2:0]  wp, rp;
  logic [7:0]  tx_data, last_out, last_keep;
  logic        scan_saved, id_resume;
  logic [1:0]  push_n;
  logic [7:0]  p0, p1, p2;
  logic        cmd_ok, opt_ok;
  wire  [7:0]  rxd      = rx_hold.data;
  wire         is_cmd   = rxd >= kbc_pkg::C_LED;
  wire         tx_busy  = tx_req_tog != ack_q;
  wire         q_empty  = wp == rp;
  wire         q_idle   = q_empty && !tx_busy;
  wire         live     = st == kbc_pkg::ST_IDLE ||
                          st == kbc_pkg::ST_OPT ||
                          st == kbc_pkg::ST_RSTW;
  wire         test_end = st == kbc_pkg::ST_TEST &&
                          tmr == 26'(TEST_CYC - 1);
  wire         acc_done = acc == 16'(ACCEPT_CYC - 1);
  wire         test_go  = (st == kbc_pkg::ST_PWRUP &&
                           tmr == 26'(PWRUP_CYC - 1)) ||
                          (st == kbc_pkg::ST_RSTW && acc_done);
  wire         prev_en  = st == kbc_pkg::ST_IDLE ? scan_en : scan_saved;

  // Link side: reset follows srst through two stages
  always_ff @(posedge link_clk) begin
    lrst_s1  <= srst;
    link_rst <= lrst_s1;
  end

  // Received byte is held until the next one; host waits for our reply
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rx_tog  <= 1'b0;
      rx_hold <= '0;
    end else if (rx_valid) begin
      rx_hold <= rx_evt;
      rx_tog  <= ~rx_tog;
    end
  end

  always_ff @(posedge link_clk) begin
    rq_s1 <= tx_req_tog;
    rq_s2 <= rq_s1;
    rq_s3 <= rq_s2;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      rq_seen  <= 1'b0;
      ack_tog  <= 1'b0;
    end else if (tx_valid) begin
      if (tx_ready) begin
        tx_valid <= 1'b0;
        ack_tog  <= ~ack_tog;
      end
    end else if (rq_s2 == rq_s3 && rq_s3 != rq_seen) begin
      tx_byte  <= tx_data;
      tx_valid <= 1'b1;
      rq_seen  <= rq_s3;
    end
  end

  // Core side synchronisers; a change counts when stages two and three agree
  always_ff @(posedge sys_clk) begin
    rx_s1  <= rx_tog;
    rx_s2  <= rx_s1;
    rx_s3  <= rx_s2;
    ack_s1 <= ack_tog;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
    lin_s1 <= {line_clk_in, line_data_in};
    lin_s2 <= lin_s1;
    lin_s3 <= lin_s2;
  end

  assign rx_ev = rx_s2 == rx_s3 && rx_s3 != rx_seen;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_seen <= 1'b0;
      ack_q   <= 1'b0;
      lin_q   <= 2'h0;
    end else begin
      if (rx_ev) begin
        rx_seen <= rx_s3;
      end
      if (ack_s2 == ack_s3) begin
        ack_q <= ack_s3;
      end
      if (lin_s2 == lin_s3) begin
        lin_q <= lin_s3;
      end
    end
  end

  // Reply decode; bytes arriving outside the live states are dropped
  always_comb begin
    push_n = 2'd0;
    p0     = kbc_pkg::R_ACK;
    p1     = kbc_pkg::R_ACK;
    p2     = kbc_pkg::R_ACK;
    cmd_ok = 1'b0;
    opt_ok = 1'b0;
    if (test_end) begin
      push_n = 2'd1;
      p0 = self_test_ok ? kbc_pkg::R_PASS : kbc_pkg::R_FAIL;
    end else if (rx_ev && live) begin
      push_n = 2'd1;
      if (rx_hold.perr) begin
        p0 = kbc_pkg::R_RESEND;
      end else if (st == kbc_pkg::ST_OPT && !is_cmd) begin
        case (opt)
          kbc_pkg::OPT_LED:  opt_ok = ~|(rxd & kbc_pkg::LED_RSV);
          kbc_pkg::OPT_RATE: opt_ok = ~rxd[7];
          kbc_pkg::OPT_SET: begin
            opt_ok = rxd <= kbc_pkg::SET_MAX;
            if (rxd == kbc_pkg::SET_QUERY) begin
              push_n = 2'd2;
              p1     = {6'h00, scan_set};
            end
          end
          default: opt_ok = 1'b1;
        endcase
        if (!opt_ok) begin
          p0 = kbc_pkg::R_RESEND;
        end
      end else if (!is_cmd || rxd == kbc_pkg::C_BAD0 ||
                   rxd == kbc_pkg::C_BAD1) begin
        p0 = kbc_pkg::R_RESEND;
      end else begin
        cmd_ok = 1'b1;
        case (rxd)
          kbc_pkg::C_ECHO: p0 = kbc_pkg::R_ECHO;
          kbc_pkg::C_RESEND: begin
            p0 = last_out == kbc_pkg::R_RESEND ? last_keep : last_out;
          end
          kbc_pkg::C_ID: begin
            push_n = 2'd3;
            p1     = ID_LO;
            p2     = ID_HI;
          end
          default: p0 = kbc_pkg::R_ACK;
        endcase
      end
    end
  end

  // Reply queue keeps the order in which replies were made
  always_ff @(posedge sys_clk) begin
    if (push_n != 2'd0) begin
      txq[wp[1:0]] <= p0;
    end
    if (push_n >= 2'd2) begin
      txq[2'(wp[1:0] + 2'd1)] <= p1;
    end
    if (push_n == 2'd3) begin
      txq[2'(wp[1:0] + 2'd2)] <= p2;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wp <= 3'h0;
    end else begin
      wp <= 3'(wp + {1'b0, push_n});
    end
  end

  // One byte in flight; the next waits for the link side to hand it over
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rp         <= 3'h0;
      tx_req_tog <= 1'b0;
      tx_data    <= 8'h00;
      last_out   <= kbc_pkg::LAST_RST;
      last_keep  <= kbc_pkg::LAST_RST;
    end else if (!q_empty && !tx_busy) begin
      tx_data    <= txq[rp[1:0]];
      rp         <= 3'(rp + 3'h1);
      tx_req_tog <= ~tx_req_tog;
      last_out   <= txq[rp[1:0]];
      if (txq[rp[1:0]] != kbc_pkg::R_RESEND) begin
        last_keep <= txq[rp[1:0]];
      end
    end
  end

  // Reset handshake: ack must have left and both lines sit high long enough
  always_ff @(posedge sys_clk) begin
    if (srst || st != kbc_pkg::ST_RSTW || !q_idle || lin_q != 2'h3) begin
      acc <= 16'h0000;
    end else if (!acc_done) begin
      acc <= 16'(acc + 16'h0001);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st    <= kbc_pkg::ST_PWRUP;
      opt   <= kbc_pkg::OPT_LED;
      tmr   <= 26'h0;
      ktype <= 2'h0;
    end else begin
      case (st)
        kbc_pkg::ST_PWRUP, kbc_pkg::ST_TEST: begin
          tmr <= 26'(tmr + 26'h1);
          if (test_go) begin
            st  <= kbc_pkg::ST_TEST;
            tmr <= 26'h0;
          end else if (test_end) begin
            st <= kbc_pkg::ST_IDLE;
          end
        end
        kbc_pkg::ST_IDLE, kbc_pkg::ST_OPT, kbc_pkg::ST_RSTW: begin
          if (st == kbc_pkg::ST_RSTW && acc_done) begin
            st  <= kbc_pkg::ST_TEST;
            tmr <= 26'h0;
          end
          if (opt_ok && opt != kbc_pkg::OPT_KEY) begin
            st <= kbc_pkg::ST_IDLE;
          end
          if (cmd_ok) begin
            st <= kbc_pkg::ST_IDLE;
            if (rxd == kbc_pkg::C_RESET) begin
              st <= kbc_pkg::ST_RSTW;
            end else if (rxd == kbc_pkg::C_LED) begin
              st  <= kbc_pkg::ST_OPT;
              opt <= kbc_pkg::OPT_LED;
            end else if (rxd == kbc_pkg::C_SET) begin
              st  <= kbc_pkg::ST_OPT;
              opt <= kbc_pkg::OPT_SET;
            end else if (rxd == kbc_pkg::C_RATE) begin
              st  <= kbc_pkg::ST_OPT;
              opt <= kbc_pkg::OPT_RATE;
            end else if (is_key(rxd)) begin
              st    <= kbc_pkg::ST_OPT;
              opt   <= kbc_pkg::OPT_KEY;
              ktype <= 2'(rxd - kbc_pkg::C_KEY_T);
            end
          end
        end
        default: st <= kbc_pkg::ST_PWRUP;
      endcase
    end
  end

  // Scanning state, lamps and configuration
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scan_en    <= 1'b0;
      scan_saved <= 1'b0;
      id_resume  <= 1'b0;
      led        <= kbc_pkg::LED_RST;
      rate_cfg   <= kbc_pkg::RATE_RST;
      scan_set   <= kbc_pkg::SET_RST;
    end else begin
      if (test_go) begin
        led      <= kbc_pkg::LED_ALL;
        scan_en  <= 1'b0;
        rate_cfg <= kbc_pkg::RATE_RST;
      end
      if (test_end) begin
        led     <= kbc_pkg::LED_RST;
        scan_en <= self_test_ok;
        if (self_test_ok) begin
          scan_set <= kbc_pkg::SET_RST;
        end
      end
      if (id_resume && q_idle && st == kbc_pkg::ST_IDLE) begin
        scan_en   <= 1'b1;
        id_resume <= 1'b0;
      end
      if (opt_ok) begin
        case (opt)
          kbc_pkg::OPT_LED: begin
            led     <= rxd[2:0];
            scan_en <= scan_saved;
          end
          kbc_pkg::OPT_RATE: begin
            rate_cfg <= rxd;
            scan_en  <= scan_saved;
          end
          kbc_pkg::OPT_SET: begin
            if (rxd != kbc_pkg::SET_QUERY) begin
              scan_set <= rxd[1:0];
            end
            scan_en <= scan_saved;
          end
          default: scan_en <= 1'b0;
        endcase
      end
      if (cmd_ok) begin
        id_resume <= rxd == kbc_pkg::C_ID;
        case (rxd)
          kbc_pkg::C_ENA: scan_en <= 1'b1;
          kbc_pkg::C_DDIS: begin
            scan_en  <= 1'b0;
            rate_cfg <= kbc_pkg::RATE_RST;
          end
          kbc_pkg::C_DEF: begin
            scan_en  <= prev_en;
            rate_cfg <= kbc_pkg::RATE_RST;
          end
          kbc_pkg::C_ID: scan_en <= 1'b0;
          kbc_pkg::C_LED, kbc_pkg::C_SET, kbc_pkg::C_RATE,
          kbc_pkg::C_KEY_T, kbc_pkg::C_KEY_MB, kbc_pkg::C_KEY_MK,
          kbc_pkg::C_RESET: begin
            scan_saved <= prev_en;
            scan_en    <= 1'b0;
          end
          default: scan_en <= prev_en;
        endcase
      end
    end
  end

  // One-cycle strobes to the scanner and key store, plus their payload and the busy level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flush_buf      <= 1'b0;
      clr_typematic  <= 1'b0;
      defaults_load  <= 1'b0;
      all_type_we    <= 1'b0;
      key_type_we    <= 1'b0;
      key_type       <= 2'h0;
      key_code       <= 8'h00;
      self_test_busy <= 1'b1;
    end else begin
      flush_buf <= cmd_ok && (rxd == kbc_pkg::C_ENA ||
                   rxd == kbc_pkg::C_DDIS || rxd == kbc_pkg::C_DEF ||
                   rxd == kbc_pkg::C_SET || is_all(rxd) ||
                   is_key(rxd));
      clr_typematic <= cmd_ok && (rxd == kbc_pkg::C_ENA ||
                       rxd == kbc_pkg::C_DDIS ||
                       rxd == kbc_pkg::C_DEF || rxd == kbc_pkg::C_SET);
      defaults_load <= cmd_ok && (rxd == kbc_pkg::C_DDIS ||
                                  rxd == kbc_pkg::C_DEF);
      all_type_we   <= cmd_ok && is_all(rxd);
      key_type_we   <= opt_ok && opt == kbc_pkg::OPT_KEY;
      key_type      <= is_all(rxd) ? 2'(rxd - kbc_pkg::C_ALL_T) : ktype;
      key_code      <= rxd;
      self_test_busy <= st == kbc_pkg::ST_PWRUP || st == kbc_pkg::ST_TEST;
    end
  end

  property p_test_leds;
    @(posedge sys_clk) disable iff (srst)
    (st == kbc_pkg::ST_TEST && !test_go) |-> led == kbc_pkg::LED_ALL;
  endproperty
  a_test_leds: assert property (p_test_leds)
    else $error("lamps not lit during self-test");

  property p_test_len;
    @(posedge sys_clk) disable iff (srst)
    test_end |=> st == kbc_pkg::ST_IDLE && led == kbc_pkg::LED_RST;
  endproperty
  a_test_len: assert property (p_test_len)
    else $error("self-test did not end on time");

  property p_test_res;
    @(posedge sys_clk) disable iff (srst)
    test_end |=> scan_en == $past(self_test_ok) && !q_empty;
  endproperty
  a_test_res: assert property (p_test_res)
    else $error("self-test result not reported");

  property p_test_ign;
    @(posedge sys_clk) disable iff (srst)
    (rx_ev && !live && !test_end) |-> push_n == 2'd0 && !cmd_ok;
  endproperty
  a_test_ign: assert property (p_test_ign)
    else $error("byte acted on during self-test");

  property p_bad_cmd;
    @(posedge sys_clk) disable iff (srst)
    (cmd_ok == 1'b0 && rx_ev && st == kbc_pkg::ST_IDLE &&
     rxd == kbc_pkg::C_BAD0) |-> p0 == kbc_pkg::R_RESEND ##1
    scan_en == $past(scan_en);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("invalid command not answered with resend");

  property p_parity;
    @(posedge sys_clk) disable iff (srst)
    (rx_ev && live && rx_hold.perr) |->
    push_n == 2'd1 && p0 == kbc_pkg::R_RESEND;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity error not answered with resend");

  property p_enable;
    @(posedge sys_clk) disable iff (srst)
    (cmd_ok && rxd == kbc_pkg::C_ENA) |=>
    scan_en && flush_buf && clr_typematic;
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable did not start scanning");

  property p_ddis;
    @(posedge sys_clk) disable iff (srst)
    (cmd_ok && rxd == kbc_pkg::C_DDIS) |=>
    !scan_en && defaults_load && rate_cfg == kbc_pkg::RATE_RST;
  endproperty
  a_ddis: assert property (p_ddis)
    else $error("default disable incomplete");

  property p_rst_off;
    @(posedge sys_clk) disable iff (srst)
    st == kbc_pkg::ST_RSTW |-> !scan_en;
  endproperty
  a_rst_off: assert property (p_rst_off)
    else $error("scanning during reset wait");

  property p_led_set;
    @(posedge sys_clk) disable iff (srst)
    (opt_ok && opt == kbc_pkg::OPT_LED) |=> led == $past(rxd[2:0]);
  endproperty
  a_led_set: assert property (p_led_set)
    else $error("lamps do not follow option byte");

  property p_tx_hold;
    @(posedge link_clk) disable iff (link_rst)
    (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_byte);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit byte dropped before taken");

  c_pass: cover property (@(posedge sys_clk) disable iff (srst)
    test_end && self_test_ok);
  c_reset: cover property (@(posedge sys_clk) disable iff (srst)
    st == kbc_pkg::ST_RSTW && acc_done);
  c_ident: cover property (@(posedge sys_clk) disable iff (srst)
    id_resume && q_idle && st == kbc_pkg::ST_IDLE);

endmodule : kbc_cmd
`default_nettype wire

// >>> tb/kbc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module kbc_host_model (
  input  wire logic        link_clk,    // Link clock
  output kbc_pkg::kbc_rx_s rx_evt,      // Byte to keyboard
  output logic             rx_valid,    // One-cycle strobe
  output logic             tx_ready,    // Takes reply byte
  input  wire logic [7:0]  tx_byte,     // Reply byte
  input  wire logic        tx_valid,    // Reply waiting
  output logic             line_clk_in, // Clock line level
  output logic             line_data_in // Data line level
);
  logic [7:0] got[$];
  logic       busy = 1'b0;
  initial begin
    rx_evt = '0;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Pull-ups hold both lines high between sends, which accepts a reset ack
  assign line_clk_in  = !busy;
  assign line_data_in = !busy;
  task automatic send(input logic [7:0] b, input logic pe);
    @(posedge link_clk);
    #1;
    busy = 1'b1;
    rx_valid = 1'b1;
    rx_evt = '{perr: pe, data: b};
    @(posedge link_clk);
    #1;
    rx_valid = 1'b0;
    rx_evt = ~rx_evt;
    busy = 1'b0;
  endtask : send
  // Random stalls so replies queue up behind a slow host
  always @(posedge link_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_byte);
    #1 tx_ready = ($urandom_range(2) == 0);
  end
endmodule : kbc_host_model
`default_nettype wire

// >>> tb/kbc_cmd_tb.sv
`timescale 1ns/1ns
`default_nettype none
module kbc_cmd_tb;
  localparam logic [7:0] ID0 = 8'h3c; // Arbitrary identity value
  localparam logic [7:0] ID1 = 8'h96; // Arbitrary identity value
  logic             sys_clk, link_clk, srst, self_test_ok;
  logic             rx_valid, tx_ready, tx_valid, lclk, ldat, scan_en;
  logic             all_type_we, key_type_we, self_test_busy, flush_buf;
  logic             clr_typematic, defaults_load;
  kbc_pkg::kbc_rx_s rx_evt;
  logic [7:0]       tx_byte, rate_cfg, key_code, rate, last, kc, b;
  logic [1:0]       scan_set, key_type, aty;
  logic [2:0]       led, lamps;
  logic             pe;
  logic [7:0]       exp[$];
  int               fails, checks, en, set, opt, ktyp, sc;
  logic [7:0]       seq[$] = '{8'hf4, 8'hf5, 8'hee, 8'hf6, 8'hf4, 8'hef,
    8'hfe, 8'hf1, 8'hfe, 8'hf2, 8'hee, 8'hf0, 8'h03, 8'hf0, 8'h00, 8'hf0,
    8'h01, 8'hf0, 8'h00, 8'hf0, 8'h02, 8'hed, 8'h05, 8'hf3, 8'h3c, 8'hf7,
    8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'h12, 8'h34, 8'hfd, 8'h56, 8'hf5, 8'hfc,
    8'h77, 8'hf6, 8'hed, 8'hf4, 8'h12, 8'h00, 8'hec};
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #2;
    forever #3 link_clk = ~link_clk;
  end
  kbc_host_model host (.link_clk(link_clk), .rx_evt(rx_evt),
    .rx_valid(rx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .line_clk_in(lclk), .line_data_in(ldat));
  kbc_cmd #(.PWRUP_CYC(20), .TEST_CYC(40), .ACCEPT_CYC(30), .ID_LO(ID0),
    .ID_HI(ID1)) dut (.sys_clk(sys_clk), .srst(srst), .link_clk(link_clk),
    .rx_valid(rx_valid), .rx_evt(rx_evt), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .line_clk_in(lclk),
    .line_data_in(ldat), .self_test_ok(self_test_ok), .scan_en(scan_en),
    .scan_set(scan_set), .led(led), .rate_cfg(rate_cfg),
    .flush_buf(flush_buf), .clr_typematic(clr_typematic),
    .defaults_load(defaults_load), .all_type_we(all_type_we),
    .key_type_we(key_type_we), .key_type(key_type), .key_code(key_code),
    .self_test_busy(self_test_busy));
  // Strobes are one cycle wide, so their payload is latched here
  always @(posedge sys_clk) begin
    if (all_type_we === 1'b1) aty <= key_type;
    if (key_type_we === 1'b1) kc <= key_code;
    sc <= sc + int'(flush_buf === 1'b1) + 4 * int'(clr_typematic === 1'b1) +
      16 * int'(defaults_load === 1'b1);
  end
  task automatic check(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic push(input logic [7:0] v);
    exp.push_back(v);
    if (v != 8'hfe) last = v;
  endtask : push
  task automatic drain();
    int n;
    n = 0;
    while (host.got.size() < exp.size() && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    // Extra settle time exposes surplus replies
    repeat (40) @(posedge sys_clk);
    check("count", 8'(host.got.size()), 8'(exp.size()));
    while (exp.size() > 0 && host.got.size() > 0)
      check("reply", host.got.pop_front(), exp.pop_front());
    exp.delete();
    host.got.delete();
    if (opt == 0) check("scan_en", 8'(scan_en), 8'(en));
    check("scan_set", 8'(scan_set), 8'(set));
    check("led", 8'(led), 8'(lamps));
    check("rate", rate_cfg, rate);
  endtask : drain
  task automatic cmd(input logic [7:0] c, input logic p);
    int s0, sx;
    s0 = sc;
    sx = int'(c inside {8'hf0, [8'hf4:8'hfd]}) +
      4 * int'(c inside {8'hf0, [8'hf4:8'hf6]}) +
      16 * int'(c inside {8'hf5, 8'hf6});
    if (p || c < 8'hed) sx = 0;
    host.send(c, p);
    if (p || (opt == 0 && c < 8'hed)) begin
      push(8'hfe);
    end else if (c < 8'hed) begin
      push(8'hfa);
      if (opt == 2 && c == 8'h00) push(8'(set));
      if (opt == 2 && c != 8'h00) set = c;
      if (opt == 1) lamps = c[2:0];
      if (opt == 4) rate = c;
      if (opt != 3) opt = 0;
    end else begin
      if (c != 8'hef && c != 8'hf1) opt = 0;
      case (c)
        8'hee: push(8'hee);
        8'hef, 8'hf1: push(8'hfe);
        8'hfe: push(last);
        default: push(8'hfa);
      endcase
      if (c == 8'hf2) push(ID0);
      if (c == 8'hf2) push(ID1);
      if (c == 8'hed) opt = 1;
      if (c == 8'hf0) opt = 2;
      if (c == 8'hf3) opt = 4;
      if (c >= 8'hfb && c <= 8'hfd) opt = 3;
      if (c >= 8'hfb && c <= 8'hfd) ktyp = c - 8'hfb;
      if (c == 8'hf4 || c == 8'hf2) en = 1;
      if (c == 8'hf5 || c == 8'hf6) rate = 8'h2b;
      if (c == 8'hf5) en = 0;
    end
    drain();
    if (!p && c >= 8'hf7 && c <= 8'hfa) check("aty", 8'(aty), c - 8'hf7);
    if (!p && opt == 3 && c < 8'hed) check("kc", kc, c);
    if (!p && opt == 3 && c < 8'hed) check("kt", 8'(key_type), 8'(ktyp));
    check("strobes", 8'(sc - s0), 8'(sx));
  endtask : cmd
  task automatic reset_cmd(input logic ok);
    @(posedge sys_clk);
    #1 self_test_ok = ok;
    push(8'hfa);
    push(ok ? 8'haa : 8'hfc);
    host.send(8'hff, 1'b0);
    opt = 0;
    en = ok;
    set = 2;
    lamps = 3'h0;
    rate = 8'h2b;
    drain();
  endtask : reset_cmd
  task automatic results();
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    #900_000;
    fails++;
    results();
  end
  initial begin
    {fails, checks, opt, ktyp, set, en} = {32'd0, 32'd0, 32'd0, 32'd0,
      32'd2, 32'd1};
    {lamps, rate, last, srst, self_test_ok} = {3'h0, 8'h2b, 8'h00, 2'b11};
    void'($urandom(53194));
    repeat (4) @(posedge sys_clk);
    #1 srst = 1'b0;
    repeat (35) @(posedge sys_clk);
    check("led_test", 8'(led), 8'h07);
    check("busy", 8'(self_test_busy), 8'h01);
    host.send(8'hf4, 1'b0);
    push(8'haa);
    drain();
    foreach (seq[i]) cmd(seq[i], 1'b0);
    cmd(8'hf4, 1'b1);
    repeat (40) begin
      b = 8'($urandom_range(8'hfe, 8'hed));
      if (opt == 0 && $urandom_range(4) == 0) b = 8'($urandom_range(8'hec));
      if (opt != 0 && $urandom_range(1) == 1)
        b = 8'($urandom_range(opt == 1 ? 7 : opt == 2 ? 3 : 8'h7f));
      pe = (opt == 0 && $urandom_range(7) == 0);
      cmd(b, pe);
    end
    reset_cmd(1'b1);
    reset_cmd(1'b0);
    cmd(8'hf4, 1'b0);
    results();
  end
endmodule : kbc_cmd_tb
`default_nettype wire
